// File: hfd_dma_ctl.v
// Purpose: host transport control for received set-device-bits and DMA-activate frames
// Assumes: link strobes are synchronous to mclk; registers reached over APB
// Notes: one beat carries one 4-byte dword of payload
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "hfd_defines.vh"
// Notes on behaviour
// - In devbits receive state wait for frame end and link status.
// - Clean devbits reception advances to the load state.
// - Errored devbits reception reports error and returns idle, no load.
// - Load error byte into shadow error register, then go idle.
// - Upper status field goes to shadow status bits 6..4.
// - Lower status field goes to shadow status bits 2..0.
// - Shadow busy bit 7 and data request bit 3 stay unchanged.
// - Interrupt flag with busy and data request clear sets interrupt pending.
// - DMA-activate frame first resolves transfer direction.
// - Error-free host-to-device DMA-activate goes to the data-out wait state.
// - Errored DMA-activate reports to link and application, returns idle.
// - Link illegal-transition in DMA-activate receive, active data-out or device-to-host forces idle.
// - Data-out wait holds until the DMA controller is initialized.
// - Active data-out sends until done; 8KB incomplete goes to DMA end.
// - At 8KB limit, close the frame and deactivate DMA engine.
// - Link abort during active data-out goes to DMA end.
// - After abort truncate and ask link to append CRC and end.
// - Soft or device reset in data-out states returns idle.
// - Leaving on reset tells link to send sync primitives.
// - DMA end confirms controller done, then idle with or without error.
// - Device-to-host state activates DMA once the controller is initialized, waits for completion, then DMA end.
// - Soft or device reset during device-to-host DMA returns idle.
module hfd_dma_ctl #(
  parameter LIMIT_BYTES = `HFD_LIMIT_BYTES
) (
  input wire mclk,
  input wire soft_reset_bit,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_devbits,
  input wire rx_dma_act,
  input wire dir_in,
  input wire rx_done,
  input wire rx_err,
  input wire [7:0] fis_error,
  input wire [2:0] upper_status_field,
  input wire [2:0] lower_status_field,
  input wire fis_irq,
  input wire link_illegal,
  input wire link_abort,
  input wire beat_sent,
  input wire xfer_done,
  input wire dma_idle,
  input wire dma_err,
  output reg dma_active,
  output reg link_close,
  output reg link_crc_end,
  output reg link_sync,
  output reg err_to_dev,
  output reg err_to_app,
  output reg irq_pending
);

  // ==========================================================
  // State and registers
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] shadow_err_r;
  reg [7:0] shadow_stat_r;
  reg soft_reset_bit_r;
  reg devrst_r;
  reg dma_init_r;
  reg aborted_r;
  reg [13:0] sent_r;
  reg [15:0] limit_cnt_r;
  wire reset_req;
  wire apb_wr;
  wire apb_rd;
  wire at_limit;
  wire [7:0] stat_load;

  assign reset_req = soft_reset_bit_r | devrst_r;
  assign apb_wr = psel & penable & pwrite & pready;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign at_limit = (sent_r + `HFD_BEAT_BYTES) >= LIMIT_BYTES[13:0];
  assign stat_load = {shadow_stat_r[`HFD_ST_BUSY], upper_status_field,
    shadow_stat_r[`HFD_ST_DRQ], lower_status_field};

  // ==========================================================
  // State codes
  // Codes also read back through the status word
  localparam [2:0] ST_IDLE = `HFD_S_IDLE;
  localparam [2:0] ST_DB_RX = `HFD_S_DB_RX;
  localparam [2:0] ST_DB_LOAD = `HFD_S_DB_LOAD;
  localparam [2:0] ST_DA_RX = `HFD_S_DA_RX;
  localparam [2:0] ST_OUT_WAIT = `HFD_S_OUT_WAIT;
  localparam [2:0] ST_OUT_ACT = `HFD_S_OUT_ACT;
  localparam [2:0] ST_END = `HFD_S_END;
  localparam [2:0] ST_IN = `HFD_S_IN;

  // ==========================================================
  // Decoded events
  wire in_out_states;
  wire db_bad;
  wire da_bad;
  wire irq_set;
  wire irq_clr;
  wire abort_hit;
  wire limit_hit;
  wire reset_exit;
  wire end_done;
  wire out_stay;
  wire in_stay;

  assign in_out_states = (state_r == ST_OUT_WAIT) | (state_r == ST_OUT_ACT) |
    (state_r == ST_IN);
  assign db_bad = (state_r == ST_DB_RX) & rx_done & rx_err;
  assign da_bad = (state_r == ST_DA_RX) & rx_err & ~link_illegal;
  // Busy and data request looked at before the load
  assign irq_set = (state_r == ST_DB_LOAD) & fis_irq & ~shadow_stat_r[`HFD_ST_BUSY] &
    ~shadow_stat_r[`HFD_ST_DRQ];
  assign irq_clr = apb_wr & (paddr == `HFD_OFF_CTRL) & pwdata[`HFD_CTRL_IPCLR];
  assign abort_hit = (state_r == ST_OUT_ACT) & link_abort & ~link_illegal & ~reset_req;
  assign limit_hit = (state_r == ST_OUT_ACT) & (state_nxt == ST_END) & ~link_abort &
    ~xfer_done;
  assign reset_exit = in_out_states & reset_req & ~link_illegal;
  assign end_done = (state_r == ST_END) & dma_idle;
  assign out_stay = (state_r == ST_OUT_ACT) & (state_nxt == ST_OUT_ACT);
  assign in_stay = (state_r == ST_IN) & (state_nxt == ST_IN);

  // ==========================================================
  // Next state
  // Active data-out priority: illegal, reset, abort or done, then limit
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rx_devbits) begin
          state_nxt = ST_DB_RX;
        end else if (rx_dma_act) begin
          state_nxt = ST_DA_RX;
        end
      end
      ST_DB_RX: begin
        if (rx_done) begin
          state_nxt = rx_err ? ST_IDLE : ST_DB_LOAD;
        end
      end
      ST_DB_LOAD: state_nxt = ST_IDLE;
      ST_DA_RX: begin
        if (link_illegal | rx_err) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = dir_in ? ST_IN : ST_OUT_WAIT;
        end
      end
      ST_OUT_WAIT: begin
        if (reset_req) begin
          state_nxt = ST_IDLE;
        end else if (dma_init_r) begin
          state_nxt = ST_OUT_ACT;
        end
      end
      ST_OUT_ACT: begin
        if (link_illegal) begin
          state_nxt = ST_IDLE;
        end else if (reset_req) begin
          state_nxt = ST_IDLE;
        end else if (link_abort | xfer_done) begin
          state_nxt = ST_END;
        end else if (beat_sent & at_limit) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        if (dma_idle) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IN: begin
        if (link_illegal | reset_req) begin
          state_nxt = ST_IDLE;
        end else if (xfer_done) begin
          state_nxt = ST_END;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Shadow error and status registers
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      shadow_err_r <= 8'h00;
      shadow_stat_r <= 8'h00;
    end else begin
      if (state_r == ST_DB_LOAD) begin
        shadow_err_r <= fis_error;
        shadow_stat_r <= stat_load;
      end
    end
  end

  // ==========================================================
  // Interrupt pending
  // A set in the same cycle as a software clear wins
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      irq_pending <= 1'b0;
    end else if (irq_set) begin
      irq_pending <= 1'b1;
    end else if (irq_clr) begin
      irq_pending <= 1'b0;
    end
  end

  // ==========================================================
  // Error status pulses
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      err_to_dev <= 1'b0;
      err_to_app <= 1'b0;
    end else begin
      err_to_dev <= 1'b0;
      err_to_app <= 1'b0;
      if (db_bad) begin
        err_to_dev <= 1'b1;
      end
      if (da_bad) begin
        err_to_dev <= 1'b1;
        err_to_app <= 1'b1;
      end
      // An abort already ended the frame toward the device
      if (end_done) begin
        err_to_dev <= dma_err & ~aborted_r;
        err_to_app <= dma_err;
      end
    end
  end

  // ==========================================================
  // Link layer requests
  // Each request stands for one cycle
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      link_close <= 1'b0;
      link_crc_end <= 1'b0;
      link_sync <= 1'b0;
    end else begin
      link_close <= limit_hit;
      link_crc_end <= abort_hit;
      link_sync <= reset_exit;
    end
  end

  // ==========================================================
  // DMA engine and payload count
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      dma_active <= 1'b0;
      sent_r <= 14'h0000;
      aborted_r <= 1'b0;
    end else begin
      // Byte count wraps above 16 KB, so the limit must stay below that
      if (out_stay) begin
        dma_active <= 1'b1;
        if (beat_sent) begin
          sent_r <= sent_r + `HFD_BEAT_BYTES;
        end
      end else if (in_stay) begin
        dma_active <= dma_init_r;
      end else begin
        dma_active <= 1'b0;
      end
      if (abort_hit) begin
        aborted_r <= 1'b1;
      end
      // Byte count and abort flag restart for the next frame
      if (state_nxt == ST_IDLE) begin
        sent_r <= 14'h0000;
        aborted_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Count of frames closed at the payload limit
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      limit_cnt_r <= 16'h0000;
    end else begin
      if (limit_hit) begin
        limit_cnt_r <= limit_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // APB slave, no wait states
  always @(posedge mclk) begin
    if (soft_reset_bit) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      soft_reset_bit_r <= 1'b0;
      devrst_r <= 1'b0;
      dma_init_r <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      devrst_r <= 1'b0;
      if (psel & ~penable) begin
        pslverr <= (paddr > `HFD_OFF_COUNT) | (paddr[1:0] != 2'h0);
      end
      if (apb_wr && paddr == `HFD_OFF_CTRL) begin
        soft_reset_bit_r <= pwdata[`HFD_CTRL_SOFT_RESET_BIT];
        devrst_r <= pwdata[`HFD_CTRL_DEVRST];
        dma_init_r <= pwdata[`HFD_CTRL_DMAINIT];
      end
      if (apb_rd) begin
        case (paddr)
          `HFD_OFF_CTRL: prdata <= {28'h0000000, irq_pending, dma_init_r, 1'b0,
            soft_reset_bit_r};
          `HFD_OFF_SHADOW: prdata <= {16'h0000, shadow_err_r, shadow_stat_r};
          `HFD_OFF_STAT: prdata <= {15'h0000, sent_r, state_r};
          `HFD_OFF_COUNT: prdata <= {16'h0000, limit_cnt_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // hfd_dma_ctl

// File: hfd_defines.vh
// Purpose: constants for the set-device-bits and DMA-activate transport control
// Assumes: 10 MHz mclk, APB register access with 32-bit words
// Notes: offsets are byte addresses
`ifndef HFD_DEFINES_VH
`define HFD_DEFINES_VH
// ==========================================================
// Register offsets
`define HFD_OFF_CTRL 8'h00
`define HFD_OFF_SHADOW 8'h04
`define HFD_OFF_STAT 8'h08
`define HFD_OFF_COUNT 8'h0C
// ==========================================================
// Control bit positions
`define HFD_CTRL_SOFT_RESET_BIT 0
`define HFD_CTRL_DEVRST 1
`define HFD_CTRL_DMAINIT 2
`define HFD_CTRL_IPCLR 3
// ==========================================================
// Shadow status bit positions
`define HFD_ST_BUSY 7
`define HFD_ST_DRQ 3
// ==========================================================
// Payload limit in bytes and per-beat size
`define HFD_LIMIT_BYTES 14'h2000
`define HFD_BEAT_BYTES 14'h0004
// ==========================================================
// States
`define HFD_S_IDLE 3'h0
`define HFD_S_DB_RX 3'h1
`define HFD_S_DB_LOAD 3'h2
`define HFD_S_DA_RX 3'h3
`define HFD_S_OUT_WAIT 3'h4
`define HFD_S_OUT_ACT 3'h5
`define HFD_S_END 3'h6
`define HFD_S_IN 3'h7
`endif

// File: hfd_far.sv
// Purpose: link and DMA controller stand-in
// Assumes: one beat a cycle while the engine runs
// Notes: stall holds beats back so an abort lands before the limit
`timescale 1ns/1ps
// ==========================================
// Far side
module hfd_far (
  input wire mclk,
  input wire dma_active,
  input wire stall,
  output logic beat_sent,
  output logic dma_idle
);
  initial begin
    beat_sent = 1'b0;
    dma_idle = 1'b1;
  end
  always @(posedge mclk) begin
    beat_sent <= dma_active & ~stall;
    dma_idle <= ~dma_active;
  end
endmodule // hfd_far

// File: hfd_chk_assertions.sv
// Purpose: port checks for the transport control
// Assumes: one mclk domain, soft_reset_bit synchronous high
// Notes: bound to every instance
`timescale 1ns/1ps
module hfd_chk (
  input wire mclk,
  input wire soft_reset_bit,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire dma_active,
  input wire link_close,
  input wire link_crc_end,
  input wire link_sync,
  input wire err_to_app,
  input wire irq_pending
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (soft_reset_bit);
  // ==========================================
  // Checks
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  reset_quiet_a: assert property ($fell(soft_reset_bit) |-> !dma_active && !irq_pending)
    else $error("outputs busy after reset");
  close_stops_dma_a: assert property (link_close |-> !dma_active ##1 !link_close)
    else $error("close with engine active");
  crc_end_pulse_a: assert property (link_crc_end |-> !dma_active ##1 !link_crc_end)
    else $error("crc end with engine active");
  sync_stops_dma_a: assert property (link_sync |-> !dma_active)
    else $error("sync with engine active");
  app_err_pulse_a: assert property (err_to_app |=> !err_to_app)
    else $error("application error held");
  cover property (link_close);
  cover property (link_crc_end);
  cover property ($rose(irq_pending));
endmodule // hfd_chk
bind hfd_dma_ctl hfd_chk u_chk (.*);

// File: testbench.sv
// Purpose: bench for the transport control
// Assumes: 10 MHz mclk, APB master tasks
// Notes: payload limit shrunk to 64 bytes
`timescale 1ns/1ps
`include "hfd_defines.vh"
module testbench;
  logic mclk = 0, soft_reset_bit = 1, psel = 0, penable = 0, pwrite = 0, pe;
  logic [7:0] paddr = 0, fis_error = 0;
  logic [31:0] pwdata = 0, d;
  logic [2:0] upper_status_field = 0, lower_status_field = 0;
  logic fis_irq = 0, dir_in = 0, dma_err = 0, stall = 0;
  logic [6:0] st = 0;
  logic [4:0] seen = 0;
  wire rx_devbits, rx_dma_act, rx_done, link_illegal, link_abort, xfer_done, rx_err;
  wire [31:0] prdata;
  wire pready, pslverr, beat_sent, dma_idle, dma_active, link_close, link_crc_end;
  wire link_sync, err_to_dev, err_to_app, irq_pending;
  int fails = 0, n_compared = 0;
  assign {rx_err, xfer_done, link_abort, link_illegal, rx_done, rx_dma_act, rx_devbits} = st;
  hfd_dma_ctl #(.LIMIT_BYTES(64)) uut (.*);
  hfd_far far (.*);
  always #50 mclk = ~mclk;
  // Sticky record of output pulses
  always @(posedge mclk) seen <= seen | {link_close, link_crc_end, link_sync, err_to_dev, err_to_app};
  task close_out;
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [32:0] g, input [32:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] wd);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    d = prdata;
    pe = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pul(input [6:0] a, input [6:0] b);
    @(posedge mclk);
    st <= a;
    @(posedge mclk);
    st <= b;
    @(posedge mclk);
    st <= 0;
  endtask
  task clr;
    @(negedge mclk);
    seen = 0;
  endtask
  initial begin
    #1000000;
    fails++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge mclk);
    soft_reset_bit <= 0;
    fis_error <= 8'hA5;
    upper_status_field <= 3'h5;
    lower_status_field <= 3'h3;
    fis_irq <= 1;
    pul(7'h01, 7'h04);
    bus(0, `HFD_OFF_SHADOW, 0);
    chk(d, 33'h0A553);
    chk(irq_pending, 1);
    bus(1, `HFD_OFF_CTRL, 32'h8);
    fis_error <= 8'h3C;
    clr;
    pul(7'h01, 7'h44);
    bus(0, `HFD_OFF_SHADOW, 0);
    chk(d, 33'h0A553);
    chk({irq_pending, seen}, 6'h02);
    clr;
    pul(7'h02, 7'h40);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h03);
    clr;
    pul(7'h02, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk({dma_active, d[2:0]}, 4'h4);
    bus(1, `HFD_OFF_CTRL, 32'h4);
    wait (seen[4]);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h10);
    bus(0, `HFD_OFF_COUNT, 0);
    chk(d, 1);
    stall <= 1;
    clr;
    pul(7'h02, 0);
    repeat (3) @(posedge mclk);
    chk(dma_active, 1);
    pul(7'h10, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h08);
    bus(1, `HFD_OFF_CTRL, 0);
    clr;
    pul(7'h02, 0);
    bus(1, `HFD_OFF_CTRL, 32'h1);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h04);
    dir_in <= 1;
    bus(1, `HFD_OFF_CTRL, 32'h4);
    pul(7'h02, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk({dma_active, d[2:0]}, 4'hF);
    pul(7'h20, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk(d[2:0], 0);
    pul(7'h02, 0);
    pul(7'h08, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk(d[2:0], 0);
    clr;
    pul(7'h02, 0);
    bus(1, `HFD_OFF_CTRL, 32'h5);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h04);
    bus(1, `HFD_OFF_CTRL, 32'h4);
    clr;
    pul(7'h02, 0);
    bus(1, `HFD_OFF_CTRL, 32'h6);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h04);
    bus(0, `HFD_OFF_CTRL, 0);
    chk(d, 32'h4);
    dma_err <= 1;
    clr;
    pul(7'h02, 0);
    pul(7'h20, 0);
    bus(0, `HFD_OFF_STAT, 0);
    chk({d[2:0], seen}, 8'h03);
    dma_err <= 0;
    bus(0, 8'h10, 0);
    chk({pe, d}, 33'h100000000);
    close_out;
  end
endmodule // testbench
